// file: logic/rrx_exec.sv
// Execution unit for return and rotate-left instructions
`timescale 1ns/1ps
module rrx_exec (
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire rrx_pkg::rrx_cmd_s i_cmd,
	input  wire logic              i_irq_pending,
	input  wire logic              i_gie_clear,
	output rrx_pkg::rrx_res_s      o_res
);

	typedef struct packed {
		rrx_pkg::rrx_state_e state;
		rrx_pkg::rrx_cmd_s   cmd;
		rrx_pkg::rrx_res_s   res;
	} rrx_state_s;

	rrx_state_s st_reg;
	rrx_state_s st_next;
	logic [12:0] top;
	logic        empty;
	logic        pop;
	logic        push;
	logic [12:0] push_data;

	////////////////////////////////////////////////////////////////////////
	// Circular left rotate
	function automatic logic [7:0] rot_plain(input logic [7:0] v);
		rot_plain = {v[6:0], v[rrx_pkg::MSB]};
	endfunction

	// Nine-bit left rotate through carry
	function automatic logic [8:0] rot_carry(input logic [7:0] v, input logic c);
		rot_carry = {v[rrx_pkg::MSB], v[6:0], c};
	endfunction

	////////////////////////////////////////////////////////////////////////
	rrx_stack #(
		.WIDTH(rrx_pkg::PC_W),
		.DEPTH(rrx_pkg::DEPTH),
		.PTR_W(rrx_pkg::PTR_W)
	) u_stack (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_push      (push),
		.i_push_data (push_data),
		.i_pop       (pop),
		.o_top       (top),
		.o_empty     (empty)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [8:0] rc;
		rc        = rot_carry(st_reg.cmd.operand, st_reg.res.carry);
		st_next   = st_reg;
		pop       = 1'b0;
		push      = 1'b0;
		push_data = st_reg.res.pc;
		st_next.res.done    = 1'b0;
		st_next.res.pc_load = 1'b0;
		st_next.res.mem_we  = 1'b0;
		st_next.res.stack_empty = empty;
		if (i_gie_clear) begin
			st_next.res.gie = 1'b0;
		end
		case (st_reg.state)
			rrx_pkg::RRX_ST_IDLE: begin
				if (i_cmd.valid) begin
					st_next.cmd   = i_cmd;
					st_next.state = rrx_pkg::RRX_ST_EXEC;
				end
			end
			rrx_pkg::RRX_ST_EXEC: begin
				st_next.state    = rrx_pkg::RRX_ST_IDLE;
				st_next.res.done = 1'b1;
				case (st_reg.cmd.op)
					rrx_pkg::RRX_CALL_EXIT: begin
						pop = 1'b1;
						st_next.res.pc      = top;
						st_next.res.pc_load = 1'b1;
					end
					rrx_pkg::RRX_CALL_EXIT_WITH_LITERAL: begin
						pop = 1'b1;
						st_next.res.pc      = top;
						st_next.res.pc_load = 1'b1;
						st_next.res.acc     = st_reg.cmd.literal;
					end
					rrx_pkg::RRX_INTERRUPT_EXIT: begin
						st_next.res.gie = 1'b1;
						if (i_irq_pending) begin
							// Return address stays stacked for the handler's own exit
							st_next.res.pc      = rrx_pkg::INT_VECTOR;
							st_next.res.pc_load = 1'b1;
							st_next.res.done    = 1'b0;
							st_next.state       = rrx_pkg::RRX_ST_VECTOR;
						end else begin
							pop = 1'b1;
							st_next.res.pc      = top;
							st_next.res.pc_load = 1'b1;
						end
					end
					rrx_pkg::RRX_ROTATE_LEFT_PLAIN: begin
						st_next.res.mem_wdata = rot_plain(st_reg.cmd.operand);
						st_next.res.mem_we    = 1'b1;
					end
					rrx_pkg::RRX_ROTATE_LEFT_INTO_WORKING: begin
						st_next.res.acc = rot_plain(st_reg.cmd.operand);
					end
					rrx_pkg::RRX_ROTATE_LEFT_THROUGH_CARRY: begin
						st_next.res.mem_wdata = rc[7:0];
						st_next.res.carry     = rc[8];
						st_next.res.mem_we    = 1'b1;
					end
					rrx_pkg::RRX_ROTATE_LEFT_CARRY_INTO_WORKING: begin
						st_next.res.acc   = rc[7:0];
						st_next.res.carry = rc[8];
					end
					rrx_pkg::RRX_CALL_ENTER: begin
						push = 1'b1;
						push_data = st_reg.cmd.push_addr;
					end
					default: begin
						st_next.res.done = 1'b1;
					end
				endcase
			end
			rrx_pkg::RRX_ST_VECTOR: begin
				// Handler entry masks further interrupts
				st_next.res.gie  = 1'b0;
				st_next.res.done = 1'b1;
				st_next.state    = rrx_pkg::RRX_ST_IDLE;
			end
			default: begin
				st_next.state = rrx_pkg::RRX_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_res = st_reg.res;

	////////////////////////////////////////////////////////////////////////
	sequence s_exec(rrx_pkg::rrx_op_e code);
		st_reg.state == rrx_pkg::RRX_ST_EXEC && st_reg.cmd.op == code;
	endsequence

	chk_ret_pc_load: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_CALL_EXIT) |=> o_res.pc == $past(top) && o_res.pc_load
			&& $stable(o_res.carry) && o_res.done)
		else $error("plain return did not load pc");

	chk_lit_acc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_CALL_EXIT_WITH_LITERAL)
			|=> o_res.acc == $past(st_reg.cmd.literal) && o_res.pc == $past(top))
		else $error("literal return wrong");

	chk_interrupt_exit_gie: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_INTERRUPT_EXIT) ##0 (!i_irq_pending && !i_gie_clear)
			|=> o_res.gie && o_res.pc == $past(top) && $stable(o_res.carry))
		else $error("interrupt return wrong");

	chk_interrupt_exit_pending: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_INTERRUPT_EXIT) ##0 i_irq_pending
			|=> o_res.pc == rrx_pkg::INT_VECTOR ##1 o_res.done && !o_res.gie)
		else $error("pending interrupt not serviced");

	chk_rl_mem: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_ROTATE_LEFT_PLAIN) |=> o_res.mem_we
			&& o_res.mem_wdata == {$past(st_reg.cmd.operand[6:0]), $past(st_reg.cmd.operand[7])}
			&& $stable(o_res.carry))
		else $error("plain rotate wrong");

	chk_rla_acc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_ROTATE_LEFT_INTO_WORKING) |=> !o_res.mem_we
			&& o_res.acc == {$past(st_reg.cmd.operand[6:0]), $past(st_reg.cmd.operand[7])})
		else $error("rotate into working wrong");

	chk_rlc_mem: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_ROTATE_LEFT_THROUGH_CARRY) |=> o_res.mem_we
			&& o_res.carry == $past(st_reg.cmd.operand[7])
			&& o_res.mem_wdata[0] == $past(st_reg.res.carry))
		else $error("carry rotate wrong");

	chk_rotate_left_carry_into_working_acc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_exec(rrx_pkg::RRX_ROTATE_LEFT_CARRY_INTO_WORKING) |=> !o_res.mem_we
			&& o_res.carry == $past(st_reg.cmd.operand[7])
			&& o_res.acc == {$past(st_reg.cmd.operand[6:0]), $past(st_reg.res.carry)})
		else $error("carry rotate into working wrong");

endmodule

// file: shared/rrx_pkg.sv
// Shared types and constants for the return and rotate-left execution unit
package rrx_pkg;

	localparam int DATA_W = 8;
	localparam int PC_W   = 13;
	localparam int DEPTH  = 8;
	localparam int PTR_W  = 3;
	localparam int MSB    = 7;
	localparam int LSB    = 0;

	localparam logic [7:0]  ACC_RESET = 8'h00;
	localparam logic [12:0] PC_RESET  = 13'h0000;
	localparam logic [12:0] INT_VECTOR = 13'h0004;

	typedef enum logic [2:0] {
		RRX_CALL_EXIT              = 3'h0,
		RRX_CALL_EXIT_WITH_LITERAL = 3'h1,
		RRX_INTERRUPT_EXIT         = 3'h2,
		RRX_ROTATE_LEFT_PLAIN      = 3'h3,
		RRX_ROTATE_LEFT_INTO_WORKING = 3'h4,
		RRX_ROTATE_LEFT_THROUGH_CARRY = 3'h5,
		RRX_ROTATE_LEFT_CARRY_INTO_WORKING = 3'h6,
		RRX_CALL_ENTER             = 3'h7
	} rrx_op_e;

	typedef enum logic [1:0] {
		RRX_ST_IDLE   = 2'b00,
		RRX_ST_EXEC   = 2'b01,
		RRX_ST_VECTOR = 2'b10
	} rrx_state_e;

	typedef struct packed {
		logic        valid;
		rrx_op_e     op;
		logic [7:0]  operand;
		logic [7:0]  literal;
		logic [12:0] push_addr;
	} rrx_cmd_s;

	typedef struct packed {
		logic        done;
		logic [12:0] pc;
		logic        pc_load;
		logic [7:0]  acc;
		logic        carry;
		logic        gie;
		logic        mem_we;
		logic [7:0]  mem_wdata;
		logic        stack_empty;
	} rrx_res_s;

endpackage

// file: logic/rrx_stack.sv
// Last-in first-out return address stack
`timescale 1ns/1ps
module rrx_stack #(
	parameter int WIDTH = rrx_pkg::PC_W,
	parameter int DEPTH = rrx_pkg::DEPTH,
	parameter int PTR_W = rrx_pkg::PTR_W
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic             i_push,
	input  wire logic [WIDTH-1:0] i_push_data,
	input  wire logic             i_pop,
	output logic      [WIDTH-1:0] o_top,
	output logic                  o_empty
);

	typedef struct packed {
		logic [PTR_W:0]                count;
		logic [DEPTH-1:0][WIDTH-1:0]   mem;
	} rrx_stack_state_s;

	rrx_stack_state_s st_reg;
	rrx_stack_state_s st_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		if (i_pop && st_reg.count != '0) begin
			st_next.count = st_reg.count - 1'b1;
		end else if (i_push && st_reg.count != (PTR_W+1)'(DEPTH)) begin
			st_next.mem[st_reg.count[PTR_W-1:0]] = i_push_data;
			st_next.count = st_reg.count + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_empty = (st_reg.count == '0);
	assign o_top   = o_empty ? '0 : st_reg.mem[st_reg.count[PTR_W-1:0] - 1'b1];

	chk_pop_one_entry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_pop && !o_empty) |=> st_reg.count == $past(st_reg.count) - 1'b1)
		else $error("pop did not remove exactly one entry");

endmodule

// file: verification/rrx_testbench.sv
// Self-checking testbench for the return and rotate-left execution unit
`timescale 1ns/1ps
module testbench;
	logic              clock;
	logic              rst_n;
	rrx_pkg::rrx_cmd_s cmd;
	logic              irq_pending;
	logic              gie_clear;
	rrx_pkg::rrx_res_s res;
	int                errors;
	int                tests_run;
	logic              seen_we;
	logic              seen_ld;

	rrx_exec dut (
		.i_clock       (clock),
		.i_rst_n       (rst_n),
		.i_cmd         (cmd),
		.i_irq_pending (irq_pending),
		.i_gie_clear   (gie_clear),
		.o_res         (res)
	);

	always #4 clock = ~clock;

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [12:0] got, input logic [12:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Issue one command and wait for its done pulse
	task automatic run_op(input rrx_pkg::rrx_op_e op, input logic [7:0] opd,
		input logic [7:0] lit, input logic [12:0] pa);
		int n;
		@(negedge clock);
		cmd = '{valid: 1'b1, op: op, operand: opd, literal: lit, push_addr: pa};
		@(negedge clock);
		cmd.valid = 1'b0;
		seen_we = 1'b0;
		seen_ld = 1'b0;
		for (n = 0; n < 8; n++) begin
			@(negedge clock);
			seen_we = seen_we | res.mem_we;
			seen_ld = seen_ld | res.pc_load;
			if (res.done === 1'b1) break;
		end
		check(res.done, 1'b1);
	endtask

	task automatic pulse_gie_clear();
		@(negedge clock);
		gie_clear = 1'b1;
		@(negedge clock);
		gie_clear = 1'b0;
		check(res.gie, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check(res.acc, 8'h00);
		check(res.carry, 1'b0);
		check(res.gie, 1'b0);
		check(res.pc, 13'h0000);
	endtask

	task automatic t_rotates();
		run_op(rrx_pkg::RRX_ROTATE_LEFT_PLAIN, 8'h81, 8'h00, 13'h0000);
		check(res.mem_wdata, 8'h03);
		check(seen_we, 1'b1);
		check(res.acc, 8'h00);
		check(res.carry, 1'b0);
		run_op(rrx_pkg::RRX_ROTATE_LEFT_INTO_WORKING, 8'h81, 8'h00, 13'h0000);
		check(res.acc, 8'h03);
		check(seen_we, 1'b0);
		check(res.carry, 1'b0);
		run_op(rrx_pkg::RRX_ROTATE_LEFT_THROUGH_CARRY, 8'h80, 8'h00, 13'h0000);
		check(res.mem_wdata, 8'h00);
		check(res.carry, 1'b1);
		check(seen_we, 1'b1);
		run_op(rrx_pkg::RRX_ROTATE_LEFT_CARRY_INTO_WORKING, 8'h41, 8'h00, 13'h0000);
		check(res.acc, 8'h83);
		check(res.carry, 1'b0);
		check(seen_we, 1'b0);
		run_op(rrx_pkg::RRX_ROTATE_LEFT_THROUGH_CARRY, 8'h81, 8'h00, 13'h0000);
		check(res.mem_wdata, 8'h02);
		check(res.carry, 1'b1);
	endtask

	task automatic t_returns();
		run_op(rrx_pkg::RRX_CALL_ENTER, 8'h00, 8'h00, 13'h0123);
		run_op(rrx_pkg::RRX_CALL_ENTER, 8'h00, 8'h00, 13'h0abc);
		check(res.stack_empty, 1'b0);
		run_op(rrx_pkg::RRX_CALL_EXIT, 8'h00, 8'h00, 13'h0000);
		check(res.pc, 13'h0abc);
		check(seen_ld, 1'b1);
		check(res.acc, 8'h83);
		check(res.carry, 1'b1);
		run_op(rrx_pkg::RRX_CALL_EXIT_WITH_LITERAL, 8'h00, 8'h5a, 13'h0000);
		check(res.pc, 13'h0123);
		check(res.acc, 8'h5a);
		check(res.carry, 1'b1);
		@(negedge clock);
		check(res.stack_empty, 1'b1);
		run_op(rrx_pkg::RRX_CALL_EXIT, 8'h00, 8'h00, 13'h0000);
		check(res.pc, 13'h0000);
		check(seen_ld, 1'b1);
	endtask

	task automatic t_int_exit();
		pulse_gie_clear();
		run_op(rrx_pkg::RRX_CALL_ENTER, 8'h00, 8'h00, 13'h0456);
		run_op(rrx_pkg::RRX_INTERRUPT_EXIT, 8'h00, 8'h00, 13'h0000);
		check(res.pc, 13'h0456);
		check(res.gie, 1'b1);
		check(res.carry, 1'b1);
	endtask

	task automatic t_int_pending();
		pulse_gie_clear();
		run_op(rrx_pkg::RRX_CALL_ENTER, 8'h00, 8'h00, 13'h0789);
		irq_pending = 1'b1;
		run_op(rrx_pkg::RRX_INTERRUPT_EXIT, 8'h00, 8'h00, 13'h0000);
		irq_pending = 1'b0;
		check(res.pc, rrx_pkg::INT_VECTOR);
		check(seen_ld, 1'b1);
		check(res.gie, 1'b0);
		run_op(rrx_pkg::RRX_INTERRUPT_EXIT, 8'h00, 8'h00, 13'h0000);
		check(res.pc, 13'h0789);
		check(res.gie, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		#80000;
		errors++;
		give_verdict();
	end

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		cmd = '0;
		irq_pending = 1'b0;
		gie_clear = 1'b0;
		errors = 0;
		tests_run = 0;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		t_reset();
		t_rotates();
		t_returns();
		t_int_exit();
		t_int_pending();
		give_verdict();
	end
endmodule
